/* hdl/spim_pkg.sv */
package spim_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_EVENT = 12'h108;
    localparam logic [11:0] OFS_EVENT_CLR = 12'h10C;
    localparam logic [11:0] OFS_IRQ_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_SCK_SEL = 12'h508;
    localparam logic [11:0] OFS_OUT_SEL = 12'h50C;
    localparam logic [11:0] OFS_IN_SEL = 12'h510;
    localparam logic [11:0] OFS_RXD = 12'h518;
    localparam logic [11:0] OFS_TXD = 12'h51C;
    localparam logic [11:0] OFS_RATE = 12'h524;
    localparam logic [11:0] OFS_CFG = 12'h554;
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int READY_BIT = 0;
    localparam int ENABLE_W = 4;
    localparam logic [3:0] ENABLE_ON = 4'h1;
    localparam int PIN_MSB = 4;
    localparam int PORT_BIT = 5;
    localparam int CONNECT_BIT = 31;
    localparam int ORDER_BIT = 0;
    localparam int CPHA_BIT = 1;
    localparam int CPOL_BIT = 2;
    localparam logic [31:0] PSEL_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] RATE_RST = 32'h0400_0000;
    localparam logic [31:0] RATE_SLOW = 32'h0200_0000;
    localparam int RATE_CODES = 7;
    localparam int RATE_RST_CODE = 1;
    localparam int NPINS = 64;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 200000;
    localparam int SLOW_KBPS = 125;
    localparam int HALF_W = 10;
    localparam logic [3:0] LAST_HALF = 4'hF;
    // Least half period of the serial clock, rounded up to cycles
    function automatic int half_cycles(input int code);
        int kbps;
        kbps = SLOW_KBPS << code;
        return (CLK_KHZ + 2 * kbps - 1) / (2 * kbps);
    endfunction
    // Shift engine states, Gray along idle, shift, done
    typedef enum logic [1:0] {
        SPIM_IDLE = 2'h0,
        SPIM_SHIFT = 2'h1,
        SPIM_DONE = 2'h3
    } spim_state_t;
endpackage

/* hdl/spim_top.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module spim_top (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic [spim_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [spim_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [spim_pkg::NPINS-1:0] PIN_IN_I,
    output logic [spim_pkg::NPINS-1:0] PIN_OUT_O,
    output logic [spim_pkg::NPINS-1:0] PIN_OE_O,
    output logic IRQ_O
);
    import spim_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic aw_held; // Write address captured
    logic w_held; // Write data captured
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] wmask; // Byte strobes widened to bits
    logic wr_do; // Both halves present, write commits
    logic ar_hs; // Read address taken
    logic [31:0] next_rdata;
    logic irq_en; // Shared by the set and clear registers
    logic event_ready; // Sticky byte-done flag
    logic [3:0] enable_reg;
    logic enabled;
    logic [31:0] sck_sel;
    logic [31:0] out_sel;
    logic [31:0] in_sel;
    logic [31:0] rate_reg;
    logic [2:0] cfg;
    logic [7:0] tx_front; // Next byte to shift
    logic [7:0] tx_back; // Queued behind it
    logic tx_front_v;
    logic tx_back_v;
    logic [7:0] tx_last; // Last written value, for read back
    logic tx_wr;
    logic [7:0] rx_front; // Readable receive stage
    logic [7:0] rx_back; // Waiting stage
    logic rx_front_v;
    logic rx_back_v;
    logic rx_pop;
    logic rx_move; // A byte lands in the readable stage
    spim_state_t state;
    logic start;
    logic [3:0] hp; // Half period index within the byte
    logic [HALF_W-1:0] cnt;
    logic [HALF_W-1:0] half_lim;
    logic [HALF_W-1:0] half_tab [RATE_CODES];
    logic tick;
    logic sck_act; // Clock in its active phase
    logic mosi;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic out_bit;
    logic [NPINS-1:0] pin_s1; // First sync stage, read by pin_s2 only
    logic [NPINS-1:0] pin_s2;
    logic miso;
    logic [NPINS-1:0] next_pin_out;
    logic [NPINS-1:0] next_pin_oe;

    // Address decode shared by both channels
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_EVENT, OFS_EVENT_CLR, OFS_IRQ_SET, OFS_IRQ_CLR,
            OFS_ENABLE, OFS_SCK_SEL, OFS_OUT_SEL, OFS_IN_SEL,
            OFS_RXD, OFS_TXD, OFS_RATE, OFS_CFG: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus slave, write channels
    // ------------------------------------------------------------
    assign S_AXI_AWREADY_O = !aw_held;
    assign S_AXI_WREADY_O = !w_held;
    assign wr_do = aw_held && w_held && !S_AXI_BVALID_O;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                    {8{w_strb[1]}}, {8{w_strb[0]}}};

    // Address and data are caught in either order
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID_I && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end
            if (wr_do)
            begin
                // Holding both until now keeps one write in flight
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (S_AXI_BREADY_I)
                S_AXI_BVALID_O <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus slave, read channels
    // ------------------------------------------------------------
    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
    assign ar_hs = S_AXI_ARVALID_I && !S_AXI_RVALID_O;
    assign rx_pop = ar_hs && (S_AXI_ARADDR_I == OFS_RXD) && rx_front_v;

    // Read mux; write-only registers read as zero
    always_comb
    begin
        case (S_AXI_ARADDR_I)
            OFS_EVENT: next_rdata = 32'(event_ready);
            OFS_IRQ_SET, OFS_IRQ_CLR: next_rdata = 32'(irq_en);
            OFS_ENABLE: next_rdata = 32'(enable_reg);
            OFS_SCK_SEL: next_rdata = sck_sel;
            OFS_OUT_SEL: next_rdata = out_sel;
            OFS_IN_SEL: next_rdata = in_sel;
            OFS_RXD: next_rdata = 32'(rx_front);
            OFS_TXD: next_rdata = 32'(tx_last);
            OFS_RATE: next_rdata = rate_reg;
            OFS_CFG: next_rdata = 32'(cfg);
            default: next_rdata = '0;
        endcase
    end

    // One read at a time; the answer comes one cycle after the address
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= next_rdata;
            S_AXI_RRESP_O <= mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RREADY_I)
            S_AXI_RVALID_O <= 1'b0;
    end

    // ------------------------------------------------------------
    // Interrupt enable, event flag and request
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            irq_en <= 1'b0;
        else if (wr_do && aw_addr == OFS_IRQ_SET && w_strb[0]
                 && w_data[READY_BIT])
            irq_en <= 1'b1;
        else if (wr_do && aw_addr == OFS_IRQ_CLR && w_strb[0]
                 && w_data[READY_BIT])
            irq_en <= 1'b0;
    end

    // A new byte in the same cycle as a clear keeps the flag set
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            event_ready <= 1'b0;
        else if (rx_move)
            event_ready <= 1'b1;
        else if (wr_do && aw_addr == OFS_EVENT_CLR && w_strb[0]
                 && w_data[READY_BIT])
            event_ready <= 1'b0;
    end

    assign IRQ_O = event_ready && irq_en;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    assign enabled = (enable_reg == ENABLE_ON);

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            enable_reg <= '0;
            sck_sel <= PSEL_RST;
            out_sel <= PSEL_RST;
            in_sel <= PSEL_RST;
            rate_reg <= RATE_RST;
            cfg <= '0;
        end
        else if (wr_do)
        begin
            case (aw_addr)
                OFS_ENABLE:
                    enable_reg <= (enable_reg & ~wmask[ENABLE_W-1:0])
                                  | (w_data[ENABLE_W-1:0]
                                  & wmask[ENABLE_W-1:0]);
                // Selectors are frozen while enabled, so pins never
                // jump under a running transfer
                OFS_SCK_SEL:
                    if (!enabled)
                        sck_sel <= (sck_sel & ~wmask) | (w_data & wmask);
                OFS_OUT_SEL:
                    if (!enabled)
                        out_sel <= (out_sel & ~wmask) | (w_data & wmask);
                OFS_IN_SEL:
                    if (!enabled)
                        in_sel <= (in_sel & ~wmask) | (w_data & wmask);
                OFS_RATE:
                    rate_reg <= (rate_reg & ~wmask) | (w_data & wmask);
                OFS_CFG:
                    cfg <= (cfg & ~wmask[2:0]) | (w_data[2:0] & wmask[2:0]);
                default:
                    enable_reg <= enable_reg; // Other offsets act elsewhere
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmit queue
    // ------------------------------------------------------------
    assign tx_wr = wr_do && aw_addr == OFS_TXD && w_strb[0];
    // The receive back stage must be free, else the byte would be lost
    assign start = enabled && state == SPIM_IDLE && tx_front_v
                   && !rx_back_v;

    // Two stages; a write with both full is dropped unless a byte starts in the same cycle
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            tx_front <= '0;
            tx_back <= '0;
            tx_front_v <= 1'b0;
            tx_back_v <= 1'b0;
            tx_last <= '0;
        end
        else
        begin
            if (tx_wr)
                tx_last <= w_data[7:0];
            case ({start, tx_wr})
                2'h2:
                begin
                    tx_front <= tx_back;
                    tx_front_v <= tx_back_v;
                    tx_back_v <= 1'b0;
                end
                2'h1:
                    if (!tx_front_v)
                    begin
                        tx_front <= w_data[7:0];
                        tx_front_v <= 1'b1;
                    end
                    else if (!tx_back_v)
                    begin
                        tx_back <= w_data[7:0];
                        tx_back_v <= 1'b1;
                    end
                2'h3:
                    if (tx_back_v)
                    begin
                        tx_front <= tx_back;
                        tx_back <= w_data[7:0];
                    end
                    else
                        tx_front <= w_data[7:0];
                default:
                    tx_front_v <= tx_front_v; // Nothing moves
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive stages
    // ------------------------------------------------------------
    assign rx_move = (rx_pop && rx_back_v)
                     || (state == SPIM_DONE && (!rx_front_v || rx_pop));

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rx_front <= '0;
            rx_back <= '0;
            rx_front_v <= 1'b0;
            rx_back_v <= 1'b0;
        end
        else if (rx_pop && rx_back_v)
        begin
            rx_front <= rx_back;
            rx_back_v <= 1'b0;
        end
        else if (state == SPIM_DONE && (!rx_front_v || rx_pop))
        begin
            rx_front <= rx_sh;
            rx_front_v <= 1'b1;
        end
        else if (state == SPIM_DONE)
        begin
            rx_back <= rx_sh;
            rx_back_v <= 1'b1;
        end
        else if (rx_pop)
            rx_front_v <= 1'b0;
    end

    // ------------------------------------------------------------
    // Rate divider
    // ------------------------------------------------------------
    for (genvar g = 0; g < RATE_CODES; g++)
    begin : g_rate
        assign half_tab[g] = HALF_W'(half_cycles(g) - 1);
    end

    // Unknown codes fall back to the reset rate
    always_comb
    begin
        half_lim = half_tab[RATE_RST_CODE];
        for (int k = 0; k < RATE_CODES; k++)
            if (rate_reg == (RATE_SLOW << k))
                half_lim = half_tab[k];
    end

    assign tick = state == SPIM_SHIFT && cnt == half_lim;

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    assign out_bit = cfg[ORDER_BIT] ? tx_sh[0] : tx_sh[7];

    // Order is read live; change it only between bytes
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state <= SPIM_IDLE;
            hp <= '0;
            cnt <= '0;
            sck_act <= 1'b0;
            mosi <= 1'b0;
            tx_sh <= '0;
            rx_sh <= '0;
        end
        else if (!enabled)
        begin
            // Disabling aborts a byte and parks the lines
            state <= SPIM_IDLE;
            sck_act <= 1'b0;
            mosi <= 1'b0;
        end
        else
        begin
            case (state)
                SPIM_IDLE:
                    if (start)
                    begin
                        state <= SPIM_SHIFT;
                        hp <= '0;
                        cnt <= '0;
                        if (!cfg[CPHA_BIT])
                        begin
                            // First bit is set up before the first edge
                            mosi <= cfg[ORDER_BIT] ? tx_front[0]
                                                   : tx_front[7];
                            tx_sh <= cfg[ORDER_BIT] ? tx_front >> 1
                                                    : tx_front << 1;
                        end
                        else
                            tx_sh <= tx_front;
                    end
                SPIM_SHIFT:
                    if (tick)
                    begin
                        cnt <= '0;
                        hp <= hp + 4'h1;
                        sck_act <= !hp[0];
                        if (hp == LAST_HALF)
                            state <= SPIM_DONE;
                        if (!hp[0] && !cfg[CPHA_BIT])
                            rx_sh <= cfg[ORDER_BIT] ? {miso, rx_sh[7:1]}
                                : {rx_sh[6:0], miso};
                        else if (hp[0] && cfg[CPHA_BIT])
                            rx_sh <= cfg[ORDER_BIT] ? {miso, rx_sh[7:1]}
                                : {rx_sh[6:0], miso};
                        else if (hp != LAST_HALF)
                        begin
                            mosi <= out_bit;
                            tx_sh <= cfg[ORDER_BIT] ? tx_sh >> 1
                                                    : tx_sh << 1;
                        end
                    end
                    else
                        cnt <= cnt + HALF_W'(1);
                SPIM_DONE:
                begin
                    state <= SPIM_IDLE;
                    mosi <= 1'b0;
                end
                default:
                    state <= SPIM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end
        else
        begin
            pin_s1 <= PIN_IN_I;
            pin_s2 <= pin_s1;
        end
    end

    // A disconnected input line reads low
    assign miso = !in_sel[CONNECT_BIT]
                  && pin_s2[in_sel[PORT_BIT:0]];

    for (genvar g = 0; g < NPINS; g++)
    begin : g_pin
        logic sck_here;
        logic mosi_here;
        assign sck_here = !sck_sel[CONNECT_BIT]
                          && sck_sel[PORT_BIT:0] == 6'(g);
        assign mosi_here = !out_sel[CONNECT_BIT]
                           && out_sel[PORT_BIT:0] == 6'(g);
        assign next_pin_oe[g] = enabled
                                && (sck_here || mosi_here);
        assign next_pin_out[g] = sck_here ? sck_act ^ cfg[CPOL_BIT]
                                          : mosi;
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            PIN_OUT_O <= '0;
            PIN_OE_O <= '0;
        end
        else
        begin
            PIN_OUT_O <= next_pin_out;
            PIN_OE_O <= next_pin_oe;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_enable_set_bit: assert property (
        wr_do && aw_addr == OFS_IRQ_SET && w_strb[0] && w_data[0]
        |=> irq_en) else $error("enable set write lost");
    chk_enable_clr_bit: assert property (
        wr_do && aw_addr == OFS_IRQ_CLR && w_strb[0] && w_data[0]
        |=> !irq_en && !IRQ_O) else $error("enable clear write lost");
    chk_irq_request: assert property (
        rx_move && irq_en |=> IRQ_O) else $error("request not raised");
    chk_event_on_move: assert property (
        $rose(rx_front_v) |-> $past(rx_move) && event_ready)
        else $error("byte landed without event");
    chk_back_waits: assert property (
        rx_back_v && !rx_pop |=> rx_back_v && $stable(rx_back))
        else $error("waiting byte moved unread");
    chk_byte_length: assert property (
        $rose(state == SPIM_DONE) |-> $past(hp) == LAST_HALF)
        else $error("byte ended early");
    chk_start_on_data: assert property (
        start |=> state == SPIM_SHIFT ##1 cnt == HALF_W'(1) || tick)
        else $error("queued byte not started");
    chk_idle_lines: assert property (
        state == SPIM_IDLE && $past(state) == SPIM_IDLE
        |-> !mosi && !sck_act) else $error("lines not parked");
    chk_pins_released: assert property (
        !enabled ##1 !enabled |-> PIN_OE_O == '0)
        else $error("pin driven while disabled");
endmodule

/* testbench/spim_slave.sv */
`timescale 1ns/1ps
// Slave that shifts a fixed reply out and collects what it hears.
// It has no select line, so the bench clears its edge count on disable.
module spim_slave (
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic en_i,
    input wire logic [2:0] mode_i,
    input wire logic [7:0] reply_i,
    output logic miso_o,
    output logic [7:0] got_o
);
    logic [3:0] e = 4'h0;
    logic [3:0] k;
    // Position advances on the change edge, one bit for two edges
    assign k = e - {3'h0, mode_i[1]};
    assign miso_o = reply_i[mode_i[0] ? k[3:1] : 3'h7 - k[3:1]];
    always @(negedge en_i) e = 4'h0;
    // Leading edge is the one that leaves the polarity level
    always @(sck_i)
    if (en_i)
    begin
        if ((sck_i != mode_i[2]) != mode_i[1])
            got_o = mode_i[0] ? {mosi_i, got_o[7:1]} : {got_o[6:0], mosi_i};
        e = e + 4'h1;
    end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    import spim_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic en = 1'b0;
    logic awr, wrdy, bv, arr, rv, irq, miso;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0000_0000, rdata, rdat;
    logic [1:0] rresp, rsp, bresp, wsp;
    logic [63:0] po, oe, pin_in;
    logic [7:0] got;
    logic [2:0] m = 3'h0;
    int failures = 0, comparisons = 0, cyc = 0;
    // Reply comes in on port 1 pin 5
    assign pin_in = 64'(miso) << 37;
    initial forever #2.5 clk = ~clk;
    spim_top i_spim_top (.SYS_CLK_I(clk), .RST_N_I(rst_n),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .PIN_IN_I(pin_in),
        .PIN_OUT_O(po), .PIN_OE_O(oe), .IRQ_O(irq));
    // Undriven clock pin rests at polarity, data pin is pulled low
    spim_slave i_spim_slave (.sck_i(oe[3] ? po[3] : m[2]),
        .mosi_i(oe[4] & po[4]), .en_i(en), .mode_i(m),
        .reply_i(8'h96), .miso_o(miso), .got_o(got));
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x)
        begin
            failures++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        // Each valid drops once, at the edge that takes it; bready stays
        // up so a following call never flips it within one time step
        do
        begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end while (bv !== 1'b1);
        wsp = bresp;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] x);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rdat = rdata;
        rsp = rresp;
        cmp(rdat, x);
    endtask
    task automatic wt;
        do
            @(posedge clk);
        while (irq !== 1'b1);
    endtask
    task tally_and_finish;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Cut a hang short well beyond the expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(OFS_RATE, RATE_RST);
        rchk(OFS_IRQ_SET, 32'h0000_0000);
        rchk(OFS_OUT_SEL, PSEL_RST);
        rchk(12'h000, 32'h0000_0000);
        cmp(32'(rsp), 32'(RESP_SLVERR));
        wr(12'h000, 32'h0000_0000);
        cmp(32'(wsp), 32'(RESP_SLVERR));
        for (int k = 0; k < RATE_CODES; k++)
        begin
            wr(OFS_RATE, RATE_SLOW << k);
            rchk(OFS_RATE, RATE_SLOW << k);
        end
        wr(OFS_SCK_SEL, 32'h0000_0003);
        wr(OFS_OUT_SEL, 32'h0000_0004);
        wr(OFS_IN_SEL, 32'h0000_0025);
        wr(OFS_IRQ_SET, 32'h0000_0001);
        cmp(32'(wsp), 32'(RESP_OKAY));
        rchk(OFS_IRQ_CLR, 32'h0000_0001);
        for (int k = 0; k < 8; k++)
        begin
            m <= k[2:0];
            wr(OFS_CFG, 32'(k));
            // Queue both bytes while idle so the back stage is really used
            wr(OFS_TXD, 32'(8'h3C ^ k));
            wr(OFS_TXD, 32'(8'hC5 ^ k));
            wr(OFS_ENABLE, 32'h0000_0001);
            en <= 1'b1;
            for (int b = 0; b < 2; b++)
            begin
                wt;
                wr(OFS_EVENT_CLR, 32'h0000_0001);
                rchk(OFS_RXD, 32'h0000_0096);
            end
            wr(OFS_OUT_SEL, 32'h0000_0007);
            rchk(OFS_OUT_SEL, 32'h0000_0004);
            cmp(32'(got), 32'(8'hC5 ^ k));
            cmp(32'({oe[4:3], po[4:3]}), 32'({3'h6, k[2]}));
            wr(OFS_ENABLE, 32'h0000_0000);
            en <= 1'b0;
        end
        wr(OFS_IRQ_CLR, 32'h0000_0001);
        rchk(OFS_IRQ_SET, 32'h0000_0000);
        cmp(32'(irq), 32'h0000_0000);
        tally_and_finish;
    end
endmodule
